// ---- verif/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk_sys_i,
   output var  logic       reg_wr_o,
   output var  logic [7:0] reg_addr_o,
   output var  logic [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   import irq_logic_pkg::*;
   logic [7:0] copy;
   initial begin
      reg_wr_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      reg_wr_o = 1'b1;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(negedge clk_sys_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      @(negedge clk_sys_i);
      d = reg_rdata_i;
   endtask
   // Output enable on, interrupt mode zero
   task automatic setup();
      wr(ADDR_INTERRUPT_CONFIG, 8'h01);
   endtask
   // Write back exactly the flags that were seen
   task automatic clr();
      rd(ADDR_INTERRUPT_STATUS, copy);
      wr(ADDR_INTERRUPT_STATUS, copy);
   endtask
endmodule
`default_nettype wire

// ---- verif/sensor_interrupt_logic_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module sensor_interrupt_logic_checker
   import irq_logic_pkg::*;
(
   input wire logic       clk_sys_i,
   input wire logic       srst_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [2:0] prox_sample_i,
   input wire logic       ambient_sample_i,
   input wire logic       response_new_i,
   input wire logic       int_n_o,
   input wire logic       int_n_oe_o
);
   logic [1:0] cfg, next_cfg;
   logic [5:0] en, next_en;
   logic [7:0] m1, next_m1;
   logic [2:0] p1, p2;
   logic       quiet;
   // Shadow copies of the written control registers
   always_comb begin
      next_cfg = cfg;
      next_en = en;
      next_m1 = m1;
      if (reg_wr_i && reg_addr_i == ADDR_INTERRUPT_CONFIG) next_cfg = reg_wdata_i[1:0];
      if (reg_wr_i && reg_addr_i == ADDR_INTERRUPT_ENABLE) next_en = reg_wdata_i[5:0];
      if (reg_wr_i && reg_addr_i == ADDR_INTERRUPT_MODE_ONE) next_m1 = reg_wdata_i;
   end
   always_ff @(posedge clk_sys_i) begin
      {cfg, en, m1, p1, p2} <= srst_i ? 22'h0 : {next_cfg, next_en, next_m1, prox_sample_i, p1};
   end
   // No event can land on the status in the next update
   assign quiet = !ambient_sample_i && !response_new_i && prox_sample_i == 3'h0 && p1 == 3'h0 && p2 == 3'h0;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   property p_oe_gated; !cfg[0] |-> !int_n_oe_o; endproperty
   a_oe_gated: assert property (p_oe_gated) else $error("pin driven while output disabled");
   property p_pin_low; int_n_o == 1'b0; endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin data not low");
   property p_set; prox_sample_i[0] && en[2] && m1[5:4] == MODE_EVERY && cfg[0] && !cfg[1] && !reg_wr_i
      ##1 !reg_wr_i [*2] |=> int_n_oe_o; endproperty
   a_set: assert property (p_set) else $error("sample did not raise pin");
   property p_hold; int_n_oe_o && !cfg[1] && !reg_wr_i |=> int_n_oe_o; endproperty
   a_hold: assert property (p_hold) else $error("pin dropped without host clear");
   property p_clear; reg_wr_i && reg_addr_i == ADDR_INTERRUPT_STATUS && reg_wdata_i[5:0] == 6'h3F && quiet
      |=> !int_n_oe_o; endproperty
   a_clear: assert property (p_clear) else $error("full clear left pin asserted");
   property p_auto; int_n_oe_o && cfg[1] && !reg_wr_i && quiet |=> !int_n_oe_o; endproperty
   a_auto: assert property (p_auto) else $error("pin did not self clear");
   property p_cfg_rd; !reg_wr_i && reg_addr_i == ADDR_INTERRUPT_CONFIG |=> reg_rdata_o == {6'h00, cfg}; endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
   property p_en_rd; !reg_wr_i && reg_addr_i == ADDR_INTERRUPT_ENABLE |=> reg_rdata_o == {2'h0, en}; endproperty
   a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
   property p_unmapped; reg_addr_i > ADDR_INTERRUPT_STATUS |=> reg_rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind sensor_interrupt_logic sensor_interrupt_logic_checker i_checker (.clk_sys_i, .srst_i, .reg_wr_i, .reg_addr_i,
   .reg_wdata_i, .reg_rdata_o, .prox_sample_i, .ambient_sample_i, .response_new_i, .int_n_o, .int_n_oe_o);
`default_nettype wire

// ---- verif/tb_sensor_interrupt_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_interrupt_logic;
   import irq_logic_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        reg_wr_i, int_n_o, int_n_oe_o;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, v;
   logic [7:0]  response_i = 8'h00;
   logic [2:0]  prox_sample_i = 3'h0;
   logic        ambient_sample_i = 1'b0;
   logic        response_new_i = 1'b0;
   logic [15:0] smp = 16'h0000, thr = 16'h0000, hy = 16'h0000;
   logic [7:0]  hi = 8'h00;
   logic [7:0]  bit_of [5] = '{8'h04, 8'h08, 8'h10, 8'h01, 8'h20};
   int          mismatches = 0;
   int          n_compared = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   host_model i_host_model (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));
   sensor_interrupt_logic i_sensor_interrupt_logic (
      .clk_sys_i, .srst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .prox_sample_i,
      .prox_one_data_i(smp), .prox_two_data_i(smp), .prox_three_data_i(smp),
      .prox_one_threshold_i(thr), .prox_two_threshold_i(thr), .prox_three_threshold_i(thr),
      .prox_hysteresis_i(hy), .prox_history_i(hi), .ambient_sample_i,
      .visible_light_channel_i(smp), .infrared_light_channel_i(smp),
      .ambient_low_threshold_i(thr), .ambient_high_threshold_i(thr),
      .response_new_i, .response_i, .int_n_o, .int_n_oe_o);
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Pulse one event source, then read the status
   task automatic fire(input int c, input logic [7:0] e);
      @(negedge clk_sys_i);
      if (c < 3) prox_sample_i[c] = 1'b1;
      else if (c == 3) ambient_sample_i = 1'b1;
      else response_new_i = 1'b1;
      @(negedge clk_sys_i);
      prox_sample_i = 3'h0;
      ambient_sample_i = 1'b0;
      response_new_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      i_host_model.rd(ADDR_INTERRUPT_STATUS, v);
      chk(v, e);
   endtask
   initial begin
      repeat (10) @(negedge clk_sys_i);
      srst_i = 1'b0;
      for (int a = 3; a <= 8; a++) begin
         i_host_model.rd(8'(a), v);
         chk(v, RESET_VALUE);
      end
      i_host_model.setup();
      i_host_model.wr(ADDR_INTERRUPT_ENABLE, 8'hFF);
      i_host_model.rd(ADDR_INTERRUPT_ENABLE, v);
      chk(v, STATUS_MASK);
      for (int c = 0; c < 5; c++) begin
         fire(c, bit_of[c]);
         chk({7'h0, int_n_oe_o}, 8'h01);
         chk({7'h0, int_n_o}, 8'h00);
         i_host_model.wr(ADDR_INTERRUPT_STATUS, 8'h00);
         i_host_model.rd(ADDR_INTERRUPT_STATUS, v);
         chk(v, bit_of[c]);
         i_host_model.clr();
         chk({7'h0, int_n_oe_o}, 8'h00);
      end
      fire(0, 8'h04);
      fire(1, 8'h0C);
      i_host_model.wr(ADDR_INTERRUPT_STATUS, 8'h04);
      i_host_model.rd(ADDR_INTERRUPT_STATUS, v);
      chk(v, 8'h08);
      i_host_model.wr(ADDR_INTERRUPT_STATUS, 8'hFF);
      i_host_model.wr(ADDR_INTERRUPT_MODE_TWO, 8'h04);
      response_i = 8'h01;
      fire(4, 8'h00);
      response_i = 8'h80;
      fire(4, 8'h20);
      i_host_model.wr(ADDR_INTERRUPT_ENABLE, 8'h3B);
      fire(0, 8'h20);
      i_host_model.clr();
      i_host_model.wr(ADDR_INTERRUPT_ENABLE, 8'h3F);
      i_host_model.wr(ADDR_INTERRUPT_MODE_ONE, 8'h30);
      thr = 16'h0064;
      smp = 16'h0032;
      fire(0, 8'h00);
      smp = 16'h00C8;
      fire(0, 8'h04);
      i_host_model.clr();
      i_host_model.wr(ADDR_INTERRUPT_CONFIG, 8'h00);
      fire(1, 8'h08);
      chk({7'h0, int_n_oe_o}, 8'h00);
      i_host_model.clr();
      i_host_model.wr(ADDR_INTERRUPT_CONFIG, 8'h03);
      fire(1, 8'h00);
      // Back to mode zero: crossing with hysteresis and a history of two samples
      i_host_model.setup();
      hy = 16'h0010;
      hi = 8'h01;
      smp = 16'h005A;
      i_host_model.wr(ADDR_INTERRUPT_MODE_ONE, 8'h11);
      fire(0, 8'h00);
      smp = 16'h0040;
      fire(0, 8'h00);
      fire(0, 8'h04);
      i_host_model.clr();
      // Ambient window: leaving then entering the low-high region
      fire(3, 8'h01);
      i_host_model.clr();
      smp = 16'h0064;
      fire(3, 8'h02);
      i_host_model.clr();
      // Proximity mode 10 raises nothing
      i_host_model.wr(ADDR_INTERRUPT_MODE_ONE, 8'h20);
      fire(0, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire

// ---- verilog/irq_logic_pkg.sv ----
// Behaviour
// - Interrupt pin is driven only while the output-enable config bit is set.
// - Pin asserts when any bit of enable AND status is one.
// - Interrupt-mode bit selects how the pin deasserts.
// - Mode zero: status stays pending until the host clears it.
// - Writing one to a status bit clears that bit only.
// - Each channel sets its status from its enable and mode fields.
// - Prox one, mode 00: set status after every completed sample.
// - Prox one, mode 01: set on threshold crossing with hysteresis and history.
// - Prox one, mode 11: set when sample above threshold; disabled gives none.
// - Prox two follows the same three modes with its own fields.
// - Prox three follows the same modes from the second mode register.
// - Ambient: bit0 per visible-channel sample or leaving window, bit1 entering window.
// - Command flag on every new response, or only new error code in mode 1.
package irq_logic_pkg;
   localparam logic [7:0] ADDR_INTERRUPT_CONFIG   = 8'h03;
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE   = 8'h04;
   localparam logic [7:0] ADDR_INTERRUPT_MODE_ONE = 8'h05;
   localparam logic [7:0] ADDR_INTERRUPT_MODE_TWO = 8'h06;
   localparam logic [7:0] ADDR_INTERRUPT_STATUS   = 8'h07;
   localparam int CFG_OUTPUT_ENABLE_BIT = 0;
   localparam int CFG_INT_MODE_BIT      = 1;
   localparam int BIT_AMBIENT_LO        = 0;
   localparam int BIT_AMBIENT_HI        = 1;
   localparam int BIT_PROX_ONE          = 2;
   localparam int BIT_PROX_TWO          = 3;
   localparam int BIT_PROX_THREE        = 4;
   localparam int BIT_COMMAND           = 5;
   localparam int PROX_ONE_MODE_LSB     = 4;
   localparam int PROX_TWO_MODE_LSB     = 6;
   localparam int PROX_THREE_MODE_LSB   = 0;
   localparam int COMMAND_MODE_LSB      = 2;
   localparam logic [7:0] RESET_VALUE   = 8'h00;
   localparam logic [7:0] STATUS_MASK   = 8'h3F;
   localparam logic [1:0] MODE_EVERY    = 2'h0;
   localparam logic [1:0] MODE_CROSS    = 2'h1;
   localparam logic [1:0] MODE_ABOVE    = 2'h3;
   localparam logic [7:0] RESP_ERR_MASK = 8'h80;
endpackage

// ---- verilog/prox_event.sv ----
`timescale 1ns/1ps
`default_nettype none
module prox_event
   import irq_logic_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk_sys_i,
   input  wire logic         srst_i,
   input  wire logic         enable_i,
   input  wire logic [1:0]   mode_i,
   input  wire logic         sample_i,
   input  wire logic [W-1:0] data_i,
   input  wire logic [W-1:0] threshold_i,
   input  wire logic [W-1:0] hysteresis_i,
   input  wire logic [7:0]   history_i,
   output logic              event_o
);
   logic       above;
   logic       next_above;
   logic [7:0] agree;
   logic [7:0] next_agree;
   logic       next_event;
   logic       cand;
   always_comb begin
      next_above = above;
      next_agree = agree;
      next_event = 1'b0;
      cand = above;
      if (sample_i) begin
         // Hysteresis band around the threshold
         if (!above && ({1'b0, data_i} > {1'b0, threshold_i} + {1'b0, hysteresis_i})) begin
            cand = 1'b1;
         end else if (above && ({1'b0, data_i} + {1'b0, hysteresis_i} < {1'b0, threshold_i})) begin
            cand = 1'b0;
         end
         // History: the new side must repeat history_i times before it counts
         if (cand != above) begin
            if (agree >= history_i) begin
               next_above = cand;
               next_agree = 8'h00;
            end else begin
               next_agree = agree + 8'h01;
            end
         end else begin
            next_agree = 8'h00;
         end
         if (enable_i) begin
            case (mode_i)
               MODE_EVERY: next_event = 1'b1;
               MODE_CROSS: next_event = (next_above != above);
               MODE_ABOVE: next_event = (data_i > threshold_i);
               default:    next_event = 1'b0;
            endcase
         end
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         above   <= 1'b0;
         agree   <= 8'h00;
         event_o <= 1'b0;
      end else begin
         above   <= next_above;
         agree   <= next_agree;
         event_o <= next_event;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/sensor_interrupt_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module sensor_interrupt_logic
   import irq_logic_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk_sys_i,
   input  wire logic         srst_i,
   input  wire logic         reg_wr_i,
   input  wire logic [7:0]   reg_addr_i,
   input  wire logic [7:0]   reg_wdata_i,
   output logic [7:0]        reg_rdata_o,
   input  wire logic [2:0]   prox_sample_i,
   input  wire logic [W-1:0] prox_one_data_i,
   input  wire logic [W-1:0] prox_two_data_i,
   input  wire logic [W-1:0] prox_three_data_i,
   input  wire logic [W-1:0] prox_one_threshold_i,
   input  wire logic [W-1:0] prox_two_threshold_i,
   input  wire logic [W-1:0] prox_three_threshold_i,
   input  wire logic [W-1:0] prox_hysteresis_i,
   input  wire logic [7:0]   prox_history_i,
   input  wire logic         ambient_sample_i,
   input  wire logic [W-1:0] visible_light_channel_i,
   input  wire logic [W-1:0] infrared_light_channel_i,
   input  wire logic [W-1:0] ambient_low_threshold_i,
   input  wire logic [W-1:0] ambient_high_threshold_i,
   input  wire logic         response_new_i,
   input  wire logic [7:0]   response_i,
   output logic              int_n_o,
   output logic              int_n_oe_o
);
   import irq_logic_pkg::*;
   logic [7:0] interrupt_config;
   logic [7:0] interrupt_enable;
   logic [7:0] interrupt_mode_one;
   logic [7:0] interrupt_mode_two;
   logic [7:0] interrupt_status;
   logic [7:0] next_config;
   logic [7:0] next_enable;
   logic [7:0] next_mode_one;
   logic [7:0] next_mode_two;
   logic [7:0] next_status;
   logic [7:0] next_rdata;
   logic       next_int_n;
   logic       next_int_n_oe;
   logic [7:0] set_bits;
   logic [2:0] prox_event;
   logic [1:0] prox_mode [3];
   logic [W-1:0] prox_data [3];
   logic [W-1:0] prox_thr [3];
   logic       amb_inside;
   logic       next_amb_inside;
   logic [W-1:0] amb_val;
   logic       amb_in_now;
   logic       pending;
   assign prox_mode[0] = interrupt_mode_one[PROX_ONE_MODE_LSB +: 2];
   assign prox_mode[1] = interrupt_mode_one[PROX_TWO_MODE_LSB +: 2];
   assign prox_mode[2] = interrupt_mode_two[PROX_THREE_MODE_LSB +: 2];
   assign prox_data[0] = prox_one_data_i;
   assign prox_data[1] = prox_two_data_i;
   assign prox_data[2] = prox_three_data_i;
   assign prox_thr[0]  = prox_one_threshold_i;
   assign prox_thr[1]  = prox_two_threshold_i;
   assign prox_thr[2]  = prox_three_threshold_i;
   // One detector per proximity channel
   for (genvar g = 0; g < 3; g++) begin : g_prox
      prox_event #(.W(W)) u_prox (
         .clk_sys_i    (clk_sys_i),
         .srst_i       (srst_i),
         .enable_i     (interrupt_enable[BIT_PROX_ONE + g]),
         .mode_i       (prox_mode[g]),
         .sample_i     (prox_sample_i[g]),
         .data_i       (prox_data[g]),
         .threshold_i  (prox_thr[g]),
         .hysteresis_i (prox_hysteresis_i),
         .history_i    (prox_history_i),
         .event_o      (prox_event[g])
      );
   end
   always_comb begin
      // Ambient: mode bit 2 picks infrared instead of visible
      amb_val = interrupt_mode_one[2] ? infrared_light_channel_i : visible_light_channel_i;
      amb_in_now = (amb_val >= ambient_low_threshold_i) && (amb_val <= ambient_high_threshold_i);
      next_amb_inside = ambient_sample_i ? amb_in_now : amb_inside;
      set_bits = 8'h00;
      set_bits[BIT_PROX_THREE:BIT_PROX_ONE] = prox_event;
      if (ambient_sample_i) begin
         if (interrupt_mode_one[1:0] == 2'h0) begin
            set_bits[BIT_AMBIENT_LO] = interrupt_enable[BIT_AMBIENT_LO] && !interrupt_mode_one[2];
         end else begin
            set_bits[BIT_AMBIENT_LO] = interrupt_enable[BIT_AMBIENT_LO] && amb_inside && !amb_in_now;
            set_bits[BIT_AMBIENT_HI] = interrupt_enable[BIT_AMBIENT_HI] && !amb_inside && amb_in_now;
         end
      end
      if (response_new_i && interrupt_enable[BIT_COMMAND]) begin
         set_bits[BIT_COMMAND] = interrupt_mode_two[COMMAND_MODE_LSB] ? |(response_i & RESP_ERR_MASK)
                                                                       : 1'b1;
      end
   end
   always_comb begin
      next_config   = interrupt_config;
      next_enable   = interrupt_enable;
      next_mode_one = interrupt_mode_one;
      next_mode_two = interrupt_mode_two;
      next_status   = interrupt_status;
      if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_INTERRUPT_CONFIG:   next_config   = reg_wdata_i & 8'h03;
            ADDR_INTERRUPT_ENABLE:   next_enable   = reg_wdata_i & STATUS_MASK;
            ADDR_INTERRUPT_MODE_ONE: next_mode_one = reg_wdata_i;
            ADDR_INTERRUPT_MODE_TWO: next_mode_two = reg_wdata_i & 8'h0F;
            ADDR_INTERRUPT_STATUS:   next_status   = interrupt_status & ~reg_wdata_i;
            default:                 next_config   = interrupt_config;
         endcase
      end
      // Interrupt mode one: flags self-clear once presented unless a register write is under way; new events in this cycle still set their own bits
      if (interrupt_config[CFG_INT_MODE_BIT] && !reg_wr_i) begin
         next_status = 8'h00;
      end
      next_status = (next_status | set_bits) & STATUS_MASK; // Set wins over clear
      case (reg_addr_i)
         ADDR_INTERRUPT_CONFIG:   next_rdata = interrupt_config;
         ADDR_INTERRUPT_ENABLE:   next_rdata = interrupt_enable;
         ADDR_INTERRUPT_MODE_ONE: next_rdata = interrupt_mode_one;
         ADDR_INTERRUPT_MODE_TWO: next_rdata = interrupt_mode_two;
         ADDR_INTERRUPT_STATUS:   next_rdata = interrupt_status;
         default:                 next_rdata = 8'h00;
      endcase
      pending = |(next_enable & next_status);
      next_int_n_oe = next_config[CFG_OUTPUT_ENABLE_BIT] && pending;
      next_int_n = 1'b0;
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         interrupt_config   <= RESET_VALUE;
         interrupt_enable   <= RESET_VALUE;
         interrupt_mode_one <= RESET_VALUE;
         interrupt_mode_two <= RESET_VALUE;
         interrupt_status   <= RESET_VALUE;
         amb_inside         <= 1'b0;
         reg_rdata_o        <= 8'h00;
         int_n_o            <= 1'b0;
         int_n_oe_o         <= 1'b0;
      end else begin
         interrupt_config   <= next_config;
         interrupt_enable   <= next_enable;
         interrupt_mode_one <= next_mode_one;
         interrupt_mode_two <= next_mode_two;
         interrupt_status   <= next_status;
         amb_inside         <= next_amb_inside;
         reg_rdata_o        <= next_rdata;
         int_n_o            <= next_int_n;
         int_n_oe_o         <= next_int_n_oe;
      end
   end
endmodule
`default_nettype wire
